// *** rtl/adcch_top.sv ***
/*
  adcch_top: one converter channel with irq condition, flag, result bytes, start
  bit and (optionally) input scan, reached over APB.
  assumes: conversion core outside; conv_done pulses with conversion_value valid;
  vector_ack pulses when the interrupt controller runs this channel's vector.
*/
// Design decision made here: the APB register port.
//
// Behaviour
// R1 - condition field bits 3:2: 00 complete, 01 below, 11 above, 10 reserved
// R2 - level field bits 1:0 enables request while flag is set
// R3 - complete condition sets flag bit 0 on each conversion
// R4 - compare conditions set flag only when threshold test passes
// R5 - vector execution clears the flag
// R6 - writing one clears flag, zero leaves it
// R7 - flag register bits 7:1 read zero; software writes zero
// R8 - signed results shown in two's complement, top bit sign
// R9 - low and high bytes form one 16-bit value
// R10 - left-adjusted: high holds 11:4, low 7:4 holds 3:0, rest zero
// R11 - right-adjusted: high 3:0 holds 11:8, low holds 7:0
// R12 - right-adjusted high 7:4 copies bit 11 when signed, else zero
// R13 - narrow mode: low holds value, high copies bit 7 when signed
// R14 - scanning only on first channel, active with nonzero span
// R15 - applied positive selection is programmed selection plus position
// R16 - position increments per conversion, wraps to zero after span
// R17 - scan covers span plus one consecutive inputs
// R18 - start bit begins conversion, hardware clears it once started
// R19 - below means less, above means greater, signed in signed mode
`timescale 1ns/100ps
module adcch_top
  import adcch_pkg::*;
#(
  parameter bit        FIRST_CHANNEL = 1'b1,
  parameter int        VALUE_WIDTH   = 12
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        conv_done,
  input  wire logic [11:0] conversion_value,
  input  wire logic        vector_ack,
  output logic             conv_start,
  output logic      [3:0]  applied_select,
  output logic      [1:0]  irq_priority_level,
  output logic             irq_request,
  output logic             irq
);
  // ****************************************************************
  // elaboration check
  // ****************************************************************
  if (VALUE_WIDTH != 12) begin : g_bad_width
    $error("adcch_top serves only a 12-bit conversion value");
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]  channel_control_r;
  logic [7:0]  channel_input_select_r;
  logic [7:0]  channel_irq_control_r;
  logic        irq_flag_r;
  logic [3:0]  scan_span_r;
  logic [1:0]  irq_status_r;
  logic [1:0]  irq_mask_r;
  logic [2:0]  mode_r;
  logic [15:0] threshold_r;
  logic [7:0]  conv_time_r;
  logic [7:0]  conv_cnt_r;
  logic        done_seen_r;
  adcch_state_e state_r;

  logic [7:0]  result_low_byte;
  logic [7:0]  result_high_byte;
  logic        below_hit;
  logic        above_hit;
  logic [3:0]  scan_pos;
  logic [3:0]  applied_sel_w;
  logic        wr_acc;
  logic        rd_acc;
  logic [5:0]  word_idx;
  logic        addr_ok;
  logic        cond_met;
  logic        flag_set;
  logic [31:0] rdata_nxt;
  logic        conv_done_q;

  assign wr_acc   = psel & penable & pwrite;
  assign rd_acc   = psel & penable & ~pwrite;
  assign word_idx = paddr[7:2];

  function automatic logic idx_is(input logic [5:0] w, input logic [3:0] idx);
    idx_is = (w == {2'b00, idx});
  endfunction : idx_is

  // ****************************************************************
  // address decode
  // ****************************************************************
  always_comb begin
    addr_ok   = 1'b1;
    rdata_nxt = 32'h0000_0000;
    if (paddr[1:0] != 2'b00) begin
      addr_ok = 1'b0;
    end else if (idx_is(word_idx, {1'b0, IDX_CHANNEL_CONTROL})) begin
      rdata_nxt[7:0] = channel_control_r;
    end else if (idx_is(word_idx, {1'b0, IDX_CHANNEL_INPUT_SEL})) begin
      rdata_nxt[7:0] = channel_input_select_r;
    end else if (idx_is(word_idx, {1'b0, IDX_CHANNEL_IRQ_CTRL})) begin
      rdata_nxt[7:0] = channel_irq_control_r;
    end else if (idx_is(word_idx, {1'b0, IDX_CHANNEL_IRQ_FLAG})) begin
      // R7 upper flag bits read zero
      rdata_nxt[FLAG_BIT] = irq_flag_r;
    end else if (idx_is(word_idx, {1'b0, IDX_CHANNEL_RES_LOW})) begin
      rdata_nxt[7:0] = result_low_byte;
    end else if (idx_is(word_idx, {1'b0, IDX_CHANNEL_RES_HIGH})) begin
      rdata_nxt[7:0] = result_high_byte;
    end else if (idx_is(word_idx, {1'b0, IDX_CHANNEL_SCAN_CTRL})) begin
      // R14 scan register exists only on the first channel
      if (FIRST_CHANNEL) begin
        rdata_nxt[7:0] = {scan_pos, scan_span_r};
      end else begin
        addr_ok = 1'b0;
      end
    end else if (idx_is(word_idx, IDX_IRQ_STATUS)) begin
      rdata_nxt[1:0] = irq_status_r;
    end else if (idx_is(word_idx, IDX_IRQ_MASK)) begin
      rdata_nxt[1:0] = irq_mask_r;
    end else if (idx_is(word_idx, IDX_MODE_CONTROL)) begin
      rdata_nxt[2:0] = mode_r;
    end else if (idx_is(word_idx, IDX_THRESHOLD)) begin
      rdata_nxt[15:0] = threshold_r;
    end else if (idx_is(word_idx, IDX_CONV_CONTROL)) begin
      rdata_nxt[7:0]  = conv_time_r;
      rdata_nxt[15:8] = conv_cnt_r;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // ****************************************************************
  // apb answer: ready in the first access cycle, data registered
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      prdata  <= (psel & ~penable & ~pwrite & addr_ok) ? rdata_nxt : 32'h0000_0000;
    end
  end

  logic wr_take;
  logic rd_take;
  assign wr_take = wr_acc & pready & addr_ok;
  assign rd_take = rd_acc & pready & addr_ok;

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_input_select_r <= RST_BYTE;
      channel_irq_control_r  <= RST_BYTE;
      scan_span_r            <= 4'h0;
      irq_mask_r             <= 2'b00;
      mode_r                 <= 3'b000;
      threshold_r            <= RST_THRESHOLD;
      conv_time_r            <= RST_CONV_TIME;
    end else if (wr_take) begin
      if (idx_is(word_idx, {1'b0, IDX_CHANNEL_INPUT_SEL})) begin
        channel_input_select_r <= pwdata[7:0] & SEL_WRITE_MASK;
      end else if (idx_is(word_idx, {1'b0, IDX_CHANNEL_IRQ_CTRL})) begin
        // R1 R2 condition and level fields
        channel_irq_control_r <= pwdata[7:0] & IRQC_WRITE_MASK;
      end else if (idx_is(word_idx, {1'b0, IDX_CHANNEL_SCAN_CTRL}) && FIRST_CHANNEL) begin
        scan_span_r <= pwdata[3:0];
      end else if (idx_is(word_idx, IDX_IRQ_MASK)) begin
        irq_mask_r <= pwdata[1:0];
      end else if (idx_is(word_idx, IDX_MODE_CONTROL)) begin
        mode_r <= pwdata[2:0];
      end else if (idx_is(word_idx, IDX_THRESHOLD)) begin
        threshold_r <= pwdata[15:0];
      end else if (idx_is(word_idx, IDX_CONV_CONTROL)) begin
        conv_time_r <= pwdata[7:0];
      end
    end
  end

  // ****************************************************************
  // conversion sequence
  // ****************************************************************
  // R18 start acted on from idle only; a set while busy is held and starts a conversion back in idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_control_r <= RST_BYTE;
    end else if (wr_take && idx_is(word_idx, {1'b0, IDX_CHANNEL_CONTROL})) begin
      channel_control_r <= {pwdata[CTRL_START_BIT] | channel_control_r[CTRL_START_BIT],
                            2'b00, pwdata[4:0] & CTRL_WRITE_MASK[4:0]};
    end else if (state_r == ADCCH_ST_IDLE && channel_control_r[CTRL_START_BIT]) begin
      // R18 cleared once started
      channel_control_r[CTRL_START_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= ADCCH_ST_IDLE;
      conv_start  <= 1'b0;
      done_seen_r <= 1'b0;
    end else begin
      conv_start  <= 1'b0;
      done_seen_r <= 1'b0;
      case (state_r)
        ADCCH_ST_IDLE: begin
          if (channel_control_r[CTRL_START_BIT]) begin
            conv_start <= 1'b1;
            state_r    <= ADCCH_ST_CONV;
          end
        end
        ADCCH_ST_CONV: begin
          if (conv_done) begin
            state_r <= ADCCH_ST_DONE;
          end
        end
        ADCCH_ST_DONE: begin
          done_seen_r <= 1'b1;
          state_r     <= ADCCH_ST_IDLE;
        end
        default: state_r <= ADCCH_ST_IDLE;
      endcase
    end
  end

  // busy cycle count, readable beside conv_time so a stuck core shows up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_cnt_r <= 8'h00;
    end else if (state_r == ADCCH_ST_CONV) begin
      conv_cnt_r <= (conv_cnt_r == 8'hFF) ? conv_cnt_r : conv_cnt_r + 8'h01;
    end else begin
      conv_cnt_r <= 8'h00;
    end
  end

  assign conv_done_q = (state_r == ADCCH_ST_CONV) & conv_done;

  // ****************************************************************
  // result and scan
  // ****************************************************************
  adcch_format u_format (
    .pclk             (pclk),
    .presetn          (presetn),
    .load             (conv_done_q),
    .conversion_value (conversion_value),
    .signed_mode      (mode_r[MODE_SIGNED_BIT]),
    .resolution       (mode_r[MODE_RES_LSB +: 2]),
    .threshold_value  (threshold_r),
    .result_low_byte  (result_low_byte),
    .result_high_byte (result_high_byte),
    .below_hit        (below_hit),
    .above_hit        (above_hit)
  );

  adcch_scan u_scan (
    .pclk                  (pclk),
    .presetn               (presetn),
    .step                  (conv_done_q),
    .wr_en                 (wr_take && FIRST_CHANNEL &&
                            idx_is(word_idx, {1'b0, IDX_CHANNEL_SCAN_CTRL})),
    .wr_pos                (pwdata[SCAN_POS_LSB +: 4]),
    .span                  (scan_span_r),
    .positive_input_select (channel_input_select_r[SEL_POS_LSB +: 4]),
    .scan_pos_r            (scan_pos),
    .applied_select        (applied_sel_w)
  );

  // ****************************************************************
  // channel flag and irq
  // ****************************************************************
  always_comb begin
    case (adcch_cond_e'(channel_irq_control_r[IRQ_COND_LSB +: 2]))
      // R3 every completion
      ADCCH_COND_COMPLETE: cond_met = 1'b1;
      // R4 R1 compare conditions
      ADCCH_COND_BELOW:    cond_met = below_hit;
      ADCCH_COND_ABOVE:    cond_met = above_hit;
      default:             cond_met = 1'b0;
    endcase
  end

  assign flag_set = done_seen_r & cond_met;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag_r <= 1'b0;
    end else if (flag_set) begin
      irq_flag_r <= 1'b1;
    end else if (vector_ack) begin
      // R5 vector clears
      irq_flag_r <= 1'b0;
    end else if (wr_take && idx_is(word_idx, {1'b0, IDX_CHANNEL_IRQ_FLAG}) &&
                 pwdata[FLAG_BIT]) begin
      // R6 write one clears
      irq_flag_r <= 1'b0;
    end
  end

  // sticky status; a read clears only the bits it returned, so an event
  // landing between setup and access is kept; a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_r <= 2'b00;
    end else begin
      irq_status_r <= (rd_take && idx_is(word_idx, IDX_IRQ_STATUS) ?
                       irq_status_r & ~prdata[1:0] : irq_status_r)
                      | {flag_set, done_seen_r};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq                <= 1'b0;
      irq_request        <= 1'b0;
      irq_priority_level <= 2'b00;
      applied_select     <= 4'h0;
    end else begin
      irq                <= |(irq_status_r & irq_mask_r);
      // R2 enabled level with flag set
      irq_request        <= irq_flag_r & (channel_irq_control_r[1:0] != 2'b00);
      irq_priority_level <= channel_irq_control_r[1:0];
      applied_select     <= applied_sel_w;
    end
  end
endmodule : adcch_top

// *** rtl/adcch_pkg.sv ***
/*
  adcch_pkg: register indices, field positions, reset values and enums for the
  converter channel block.
  assumes: APB with 32-bit data; each 8-bit register sits in the low byte of a word.
*/
package adcch_pkg;
  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [2:0] IDX_CHANNEL_CONTROL   = 3'h0;
  localparam logic [2:0] IDX_CHANNEL_INPUT_SEL = 3'h1;
  localparam logic [2:0] IDX_CHANNEL_IRQ_CTRL  = 3'h2;
  localparam logic [2:0] IDX_CHANNEL_IRQ_FLAG  = 3'h3;
  localparam logic [2:0] IDX_CHANNEL_RES_LOW   = 3'h4;
  localparam logic [2:0] IDX_CHANNEL_RES_HIGH  = 3'h5;
  localparam logic [2:0] IDX_CHANNEL_SCAN_CTRL = 3'h6;
  localparam logic [3:0] IDX_IRQ_STATUS        = 4'h8;
  localparam logic [3:0] IDX_IRQ_MASK          = 4'h9;
  localparam logic [3:0] IDX_MODE_CONTROL      = 4'hA;
  localparam logic [3:0] IDX_THRESHOLD         = 4'hB;
  localparam logic [3:0] IDX_CONV_CONTROL      = 4'hC;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_START_BIT   = 7;
  localparam int CTRL_WMASK_BITS  = 5;
  localparam int SEL_POS_LSB      = 3;
  localparam int IRQ_COND_LSB     = 2;
  localparam int FLAG_BIT         = 0;
  localparam int SCAN_POS_LSB     = 4;
  localparam int MODE_SIGNED_BIT  = 0;
  localparam int MODE_RES_LSB     = 1;
  localparam int STAT_DONE_BIT    = 0;
  localparam int STAT_HIT_BIT     = 1;
  localparam int CONV_TIME_LSB    = 0;

  // ****************************************************************
  // reset values and masks
  // ****************************************************************
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [7:0]  CTRL_WRITE_MASK = 8'h1F;
  localparam logic [7:0]  SEL_WRITE_MASK  = 8'h7F;
  localparam logic [7:0]  IRQC_WRITE_MASK = 8'h0F;
  localparam logic [15:0] RST_THRESHOLD   = 16'h0000;
  localparam logic [7:0]  RST_CONV_TIME   = 8'h04;

  // ****************************************************************
  // enumerations
  // ****************************************************************
  typedef enum logic [1:0] {
    ADCCH_COND_COMPLETE = 2'b00,
    ADCCH_COND_BELOW    = 2'b01,
    ADCCH_COND_RSVD     = 2'b10,
    ADCCH_COND_ABOVE    = 2'b11
  } adcch_cond_e;

  typedef enum logic [1:0] {
    ADCCH_RES_12R = 2'b00,
    ADCCH_RES_8   = 2'b10,
    ADCCH_RES_12L = 2'b11,
    ADCCH_RES_X   = 2'b01
  } adcch_res_e;

  typedef enum logic [2:0] {
    ADCCH_ST_IDLE = 3'b001,
    ADCCH_ST_CONV = 3'b010,
    ADCCH_ST_DONE = 3'b100
  } adcch_state_e;
endpackage : adcch_pkg

// *** rtl/adcch_format.sv ***
/*
  adcch_format: packs a 12-bit conversion value into the low/high result bytes
  and weighs it against the threshold; registered outputs.
  assumes: value is already two's complement when signed is set.
*/
`timescale 1ns/100ps
module adcch_format
  import adcch_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        load,
  input  wire logic [11:0] conversion_value,
  input  wire logic        signed_mode,
  input  wire logic [1:0]  resolution,
  input  wire logic [15:0] threshold_value,
  output logic      [7:0]  result_low_byte,
  output logic      [7:0]  result_high_byte,
  output logic             below_hit,
  output logic             above_hit
);
  logic        wide_sign_bit;
  logic        narrow_sign_bit;
  logic [15:0] packed_nxt;
  logic [15:0] cmp_val;

  assign wide_sign_bit   = conversion_value[11];
  assign narrow_sign_bit = conversion_value[7];

  // ****************************************************************
  // result packing
  // ****************************************************************
  always_comb begin
    case (adcch_res_e'(resolution))
      // R10 left-adjusted packing
      ADCCH_RES_12L: packed_nxt = {conversion_value, 4'h0};
      // R13 narrow with sign fill
      ADCCH_RES_8:   packed_nxt = {{8{signed_mode & narrow_sign_bit}}, conversion_value[7:0]};
      // R11 R12 right-adjusted with sign fill
      default:       packed_nxt = {{4{signed_mode & wide_sign_bit}}, conversion_value};
    endcase
  end

  // compare against the value as presented so the threshold uses the same scale
  assign cmp_val = packed_nxt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_low_byte  <= RST_BYTE;
      result_high_byte <= RST_BYTE;
      below_hit        <= 1'b0;
      above_hit        <= 1'b0;
    end else if (load) begin
      // R8 R9 one 16-bit two's complement value
      result_low_byte  <= packed_nxt[7:0];
      result_high_byte <= packed_nxt[15:8];
      // R19 signed or unsigned compare
      if (signed_mode) begin
        below_hit <= $signed(cmp_val) < $signed(threshold_value);
        above_hit <= $signed(cmp_val) > $signed(threshold_value);
      end else begin
        below_hit <= cmp_val < threshold_value;
        above_hit <= cmp_val > threshold_value;
      end
    end
  end
endmodule : adcch_format

// *** rtl/adcch_scan.sv ***
/*
  adcch_scan: scan position counter for the first channel.
  assumes: step pulses once per finished conversion.
*/
`timescale 1ns/100ps
module adcch_scan
  import adcch_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       step,
  input  wire logic       wr_en,
  input  wire logic [3:0] wr_pos,
  input  wire logic [3:0] span,
  input  wire logic [3:0] positive_input_select,
  output logic      [3:0] scan_pos_r,
  output logic      [3:0] applied_select
);
  // R14 active when span nonzero
  logic scan_on;
  assign scan_on = (span != 4'h0);

  // ****************************************************************
  // position counter
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_pos_r <= 4'h0;
    end else if (step && scan_on) begin
      // R16 R17 wrap after span
      scan_pos_r <= (scan_pos_r >= span) ? 4'h0 : scan_pos_r + 4'h1;
    end else if (wr_en) begin
      scan_pos_r <= wr_pos;
    end
  end

  // R15 applied selection is base plus position; wraps in four bits
  assign applied_select = scan_on ? positive_input_select + scan_pos_r : positive_input_select;
endmodule : adcch_scan

// *** bench/adcch_properties.sv ***
/* adcch_properties: bus, start and interrupt checks on adcch_top ports.
   assumes: one pclk domain, bound to every adcch_top instance. */
`timescale 1ns/100ps
module adcch_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        conv_done,
  input wire logic        vector_ack,
  input wire logic        conv_start,
  input wire logic [1:0]  irq_priority_level,
  input wire logic        irq_request
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_start_wr; psel && penable && pready && pwrite && paddr == 8'h00 && pwdata[7];
  endsequence
  bus_answer_a: assert property (s_setup |=> pready ##1 !pready)
    else $error("answer not one cycle after setup");
  err_answer_a: assert property (pslverr |-> pready) else $error("error without answer");
  idle_data_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read answer");
  flag_bits_a: assert property (pready && !pwrite && paddr == 8'h0C |-> prdata[31:1] == 31'h0)
    else $error("flag register upper bits set");
  start_pulse_a: assert property (s_start_wr |-> ##[1:3] conv_start)
    else $error("start write gave no start pulse");
  start_single_a: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  level_gate_a: assert property (irq_request |-> irq_priority_level != 2'h0)
    else $error("request with level zero");
  vector_clear_a: assert property (vector_ack && !$past(conv_done, 2) |-> ##2 !irq_request)
    else $error("vector did not clear request");
endmodule : adcch_properties

bind adcch_top adcch_properties chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .conv_done(conv_done), .vector_ack(vector_ack),
  .conv_start(conv_start), .irq_priority_level(irq_priority_level),
  .irq_request(irq_request));

// *** bench/testbench.sv ***
/* testbench: register-level tests of adcch_top over APB.
   assumes: checker bound by its own file; core and vector sides driven here. */
`timescale 1ns/100ps
module testbench import adcch_pkg::*;;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        conv_done = 1'b0;
  logic [11:0] conversion_value = 12'h000;
  logic        vector_ack = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, conv_start, irq_request, irq, err;
  logic [3:0]  applied_select;
  logic [1:0]  irq_priority_level;
  logic [39:0] fmt [6];
  logic [55:0] cmp [7];
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          k;

  adcch_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_done(conv_done), .conversion_value(conversion_value),
    .vector_ack(vector_ack), .conv_start(conv_start), .applied_select(applied_select),
    .irq_priority_level(irq_priority_level), .irq_request(irq_request), .irq(irq));

  always #5 pclk = ~pclk;

  // run takes about 440 cycles; a hang is cut at 6000
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  // answer taken at the rising edge that sees pready; request released there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask : rchk

  // registered outputs need two edges to follow a register write
  task automatic settle();
    repeat (2) @(negedge pclk);
  endtask : settle

  task automatic conv(input logic [11:0] v);
    wr(8'h00, 32'h80);
    while (conv_start !== 1'b1) @(negedge pclk);
    @(posedge pclk);
    conv_done <= 1'b1;
    conversion_value <= v;
    @(posedge pclk);
    conv_done <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : conv

  initial begin
    fmt = '{40'h00_0ABC_BC_0A, 40'h00_09AB_AB_09, 40'h01_09AB_AB_F9, 40'h07_09AB_B0_9A,
            40'h05_0085_85_FF, 40'h04_0085_85_00};
    cmp = '{56'h05_00_0100_0200_00, 56'h05_00_0100_00FF_01, 56'h0D_00_0100_0100_00,
            56'h0D_00_0100_0101_01, 56'h05_01_0000_0FFF_01, 56'h0D_01_0000_0FFF_00,
            56'h09_00_0100_0200_00};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (k = 0; k < 7; k++) rchk("reset", 8'(k * 4), {24'h0, RST_BYTE});
    rchk("conv time", 8'h30, {24'h0, RST_CONV_TIME});
    wr(8'h24, 32'h3);
    wr(8'h08, 32'h1);
    for (k = 0; k < 6; k++) begin
      wr(8'h28, {24'h0, fmt[k][39:32]});
      conv(fmt[k][27:16]);
      rchk("low", 8'h10, {24'h0, fmt[k][15:8]});
      rchk("high", 8'h14, {24'h0, fmt[k][7:0]});
      chk("request", 32'(irq_request), 32'h1);
    end
    rchk("start", 8'h00, 32'h0);
    wr(8'h0C, 32'h0);
    rchk("flag", 8'h0C, 32'h1);
    wr(8'h0C, 32'h1);
    rchk("flag", 8'h0C, 32'h0);
    chk("irq", 32'(irq), 32'h1);
    rchk("status", 8'h20, 32'h3);
    settle();
    chk("irq", 32'(irq), 32'h0);
    wr(8'h24, 32'h0);
    conv(12'h100);
    settle();
    chk("irq", 32'(irq), 32'h0);
    wr(8'h24, 32'h3);
    settle();
    chk("irq", 32'(irq), 32'h1);
    wr(8'h08, 32'h0);
    settle();
    chk("request", 32'(irq_request), 32'h0);
    wr(8'h08, 32'h3);
    settle();
    chk("request", 32'(irq_request), 32'h1);
    chk("level", 32'(irq_priority_level), 32'h3);
    @(posedge pclk);
    vector_ack <= 1'b1;
    @(posedge pclk);
    vector_ack <= 1'b0;
    settle();
    chk("request", 32'(irq_request), 32'h0);
    rchk("flag", 8'h0C, 32'h0);
    for (k = 0; k < 7; k++) begin
      wr(8'h08, {24'h0, cmp[k][55:48]});
      wr(8'h28, {24'h0, cmp[k][47:40]});
      wr(8'h2C, {16'h0, cmp[k][39:24]});
      wr(8'h0C, 32'h1);
      conv(cmp[k][19:8]);
      rchk("compare", 8'h0C, {24'h0, cmp[k][7:0]});
    end
    wr(8'h28, 32'h0);
    wr(8'h04, 32'h10);
    wr(8'h18, 32'h2);
    for (k = 0; k < 4; k++) begin
      settle();
      chk("applied", 32'(applied_select), 32'(2 + k % 3));
      rchk("scan", 8'h18, 32'((k % 3) * 16 + 2));
      conv(12'h000);
    end
    wr(8'h18, 32'h0);
    conv(12'h000);
    settle();
    chk("applied", 32'(applied_select), 32'h2);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    chk("unmapped", rd, 32'h0);
    apb(1'b1, 8'h01, 32'hFF);
    chk("unaligned", {31'h0, err}, 32'h1);
    end_sim();
  end
endmodule : testbench
